// ===== src/panc_top.sv
// module: per-port autoneg advertisement and link setup control
`timescale 1ns/1ps
module panc_top
  import panc_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // link side, from the phy pins
  input  wire logic       partner_an_in,
  input  wire logic [5:0] partner_adv_in,
  input  wire logic       sense_valid_in,
  input  wire logic [1:0] sense_speed_in,
  input  wire logic       sense_dup_known_in,
  input  wire logic       sense_full_in,
  input  wire logic       pair_swapped_in,
  input  wire logic       pol_reversed_in,
  // link results
  output logic      [5:0] adv_out,
  output logic            adv_fc_out,
  output logic            link_up_out,
  output logic      [1:0] speed_out,
  output logic            full_dup_out,
  output logic            mdix_out,
  output logic            pol_inv_out
);
  import panc_pkg::*;

  logic [1:0] rst_sync_reg;
  wire        rst_n;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) rst_sync_reg <= 2'b00;
    else          rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // pin synchronisers, two stages
  localparam int PW = 15;
  logic [PW-1:0] pin_s1_reg;
  logic [PW-1:0] pin_s2_reg;
  wire  [PW-1:0] pin_raw;
  assign pin_raw = {partner_an_in, partner_adv_in, sense_valid_in,
                    sense_speed_in, sense_dup_known_in, sense_full_in,
                    pair_swapped_in, pol_reversed_in, 1'b0};
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire       p_an      = pin_s2_reg[14];
  wire [5:0] p_adv     = pin_s2_reg[13:8];
  wire       s_valid   = pin_s2_reg[7];
  wire [1:0] s_speed   = pin_s2_reg[6:5];
  wire       s_known   = pin_s2_reg[4];
  wire       s_full    = pin_s2_reg[3];
  wire       p_swapped = pin_s2_reg[2];
  wire       p_polrev  = pin_s2_reg[1];

  // software registers
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [5:0] cadv_reg;
  logic       restart_reg;
  wire        wr_ctrl = wr_in && (addr_in == OFS_CTRL);
  wire        wr_adv  = wr_in && (addr_in == OFS_ADV);
  wire        an_en   = ctrl_reg[CTRL_AN_EN];
  assign ctrl_next = {4'h0, 1'b0, wdata_in[2:0]};
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= CTRL_RST;
      cadv_reg    <= ADV_RST[5:0];
      restart_reg <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_next;
      if (wr_adv)  cadv_reg <= wdata_in[5:0];
      restart_reg <= wr_ctrl && wdata_in[CTRL_RESTART];
    end
  end

  // configured advert: all modes or the custom set
  wire [5:0] cfg_adv = ctrl_reg[CTRL_CUSTOM] ? cadv_reg : ABIL_ALL;

  // active advert latched only at restart
  logic [5:0] adv_reg;
  logic       fc_reg;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      adv_reg <= ABIL_ALL;
      fc_reg  <= FC_NONE;
    end else if (restart_reg) begin
      adv_reg <= cfg_adv;
      fc_reg  <= ctrl_reg[CTRL_FC];
    end
  end

  // resolver
  panc_res_if ri ();
  assign ri.local_adv   = adv_reg;
  assign ri.partner_adv = p_adv;
  panc_resolve u_res (
    .ri (ri)
  );

  // negotiation sequencer
  panc_state_e st_reg;
  panc_state_e st_next;
  logic [15:0] cnt_reg;
  logic        link_reg;
  logic [1:0]  spd_reg;
  logic        fd_reg;
  wire         settled = (cnt_reg == 16'(SETTLE - 1));

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PANC_IDLE:  st_next = !an_en ? PANC_SENSE
                          : (p_an ? PANC_EXCH : PANC_SENSE);
      PANC_EXCH:  if (settled) st_next = ri.found ? PANC_UP
                                                  : PANC_DOWN;
      PANC_SENSE: if (s_valid) st_next = PANC_UP;
      PANC_UP:    st_next = PANC_UP;
      PANC_DOWN:  st_next = PANC_DOWN;
      default:    st_next = PANC_IDLE;
    endcase
    if (restart_reg) st_next = PANC_IDLE;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_reg  <= PANC_IDLE;
      cnt_reg <= 16'h0000;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= (st_reg == PANC_EXCH && !settled) ?
                 cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // link result; a non-common advert keeps the link down
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= 1'b0;
      spd_reg  <= SPD_10;
      fd_reg   <= 1'b0;
    end else if (st_reg == PANC_EXCH && settled) begin
      link_reg <= ri.found;
      spd_reg  <= ri.speed;
      fd_reg   <= ri.full_dup;
    end else if (st_reg == PANC_SENSE && s_valid) begin
      link_reg <= 1'b1;
      spd_reg  <= s_speed;
      fd_reg   <= s_known && s_full;
    end else if (st_next == PANC_IDLE) begin
      link_reg <= 1'b0;
    end
  end

  // crossover and polarity correction gated by the autoneg enable bit
  logic mdix_reg;
  logic pol_reg;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mdix_reg <= 1'b0;
      pol_reg  <= 1'b0;
    end else begin
      mdix_reg <= an_en && p_swapped;
      pol_reg  <= an_en && p_polrev;
    end
  end

  // read port, data valid one cycle after the strobe
  wire [7:0] status_w = {3'h0, pol_reg, mdix_reg, 3'(st_reg)};
  wire [7:0] link_w   = {4'h0, fd_reg, spd_reg, link_reg};
  wire [7:0] rd_mux   = (addr_in == OFS_CTRL)   ? ctrl_reg
                      : (addr_in == OFS_ADV)    ? {2'h0, cadv_reg}
                      : (addr_in == OFS_STATUS) ? status_w
                      : (addr_in == OFS_LINK)   ? link_w : 8'h00;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) rdata_out <= 8'h00;
    else        rdata_out <= rd_in ? rd_mux : 8'h00;
  end

  // outputs straight from flops
  assign adv_out      = adv_reg;
  assign adv_fc_out   = fc_reg;
  assign link_up_out  = link_reg;
  assign speed_out    = spd_reg;
  assign full_dup_out = fd_reg;
  assign mdix_out     = mdix_reg;
  assign pol_inv_out  = pol_reg;
endmodule // panc_top

// ===== src/panc_pkg.sv
// package: constants and types for the port autoneg advert control
package panc_pkg;
  // ability vector bit positions
  localparam int ABIL_W       = 6;
  localparam int AB_10HD      = 0;
  localparam int AB_10FD      = 1;
  localparam int AB_100HD     = 2;
  localparam int AB_100FD     = 3;
  localparam int AB_1000HD    = 4;
  localparam int AB_1000FD    = 5;
  localparam logic [5:0] ABIL_ALL = 6'h3f;
  // speed codes
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // flow control advert codes
  localparam logic FC_NONE = 1'b0;
  localparam logic FC_ASYM = 1'b1;
  // register offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_ADV    = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_LINK   = 4'h3;
  // control field positions
  localparam int CTRL_AN_EN   = 0;
  localparam int CTRL_CUSTOM  = 1;
  localparam int CTRL_FC      = 2;
  localparam int CTRL_RESTART = 3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] ADV_RST  = 8'h3f;
  // link settle time and cycle count at 40 MHz
  localparam int CLK_MHZ       = 40;
  localparam int SETTLE_US     = 10;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  typedef enum logic [2:0] {
    PANC_IDLE, PANC_EXCH, PANC_SENSE, PANC_UP, PANC_DOWN
  } panc_state_e;
endpackage

// ===== src/panc_res_if.sv
// interface: resolver inputs and result between the modules
`timescale 1ns/1ps
interface panc_res_if;
  logic [5:0] local_adv;
  logic [5:0] partner_adv;
  logic       found;
  logic [1:0] speed;
  logic       full_dup;
  modport ctrl (output local_adv, output partner_adv,
                input found, input speed, input full_dup);
  modport res  (input local_adv, input partner_adv,
                output found, output speed, output full_dup);
endinterface

// ===== src/panc_resolve.sv
// module: highest common ability resolver
`timescale 1ns/1ps
module panc_resolve
  import panc_pkg::*;
(
  panc_res_if.res ri
);
  wire [5:0] common;
  assign common = ri.local_adv & ri.partner_adv;
  // walk down from 1000 full to the first shared mode
  always_comb begin
    ri.found    = 1'b1;
    ri.speed    = SPD_10;
    ri.full_dup = 1'b0;
    if (common[AB_1000FD]) begin
      ri.speed    = SPD_1000;
      ri.full_dup = 1'b1;
    end else if (common[AB_1000HD]) begin
      ri.speed    = SPD_1000;
    end else if (common[AB_100FD]) begin
      ri.speed    = SPD_100;
      ri.full_dup = 1'b1;
    end else if (common[AB_100HD]) begin
      ri.speed    = SPD_100;
    end else if (common[AB_10FD]) begin
      ri.full_dup = 1'b1;
    end else if (!common[AB_10HD]) begin
      ri.found    = 1'b0;
    end
  end
endmodule // panc_resolve

// ===== sim/panc_top_properties.sv
// checker: port level properties of panc_top
`timescale 1ns/1ps
module panc_top_properties
  import panc_pkg::*;
#(
  parameter int SETTLE = 4
) (
  // clock, reset and register port
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  // link side and results
  input wire logic       pair_swapped_in,
  input wire logic       pol_reversed_in,
  input wire logic [5:0] adv_out,
  input wire logic       adv_fc_out,
  input wire logic       link_up_out,
  input wire logic [1:0] speed_out,
  input wire logic       full_dup_out,
  input wire logic       mdix_out,
  input wire logic       pol_inv_out
);
  // cycles since last restart write
  logic [2:0] age_reg;
  logic [2:0] age_next;
  wire        rs_wr;
  assign rs_wr = wr_in && addr_in == OFS_CTRL && wdata_in[CTRL_RESTART];
  assign age_next = rs_wr ? 3'h0 : (&age_reg ? age_reg : age_reg + 3'h1);
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in) age_reg <= 3'h7;
    else age_reg <= age_next;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero");
  a_link_read: assert property ($past(rd_in && addr_in == OFS_LINK) |->
    rdata_out == $past({4'h0, full_dup_out, speed_out, link_up_out}))
    else $error("link read mismatch");
  a_status_read: assert property ($past(rd_in && addr_in == OFS_STATUS)
    |-> rdata_out[4:3] == $past({pol_inv_out, mdix_out}))
    else $error("status read mismatch");
  a_unmapped_zero: assert property ($past(rd_in && addr_in > 4'h3) |->
    rdata_out == 8'h00) else $error("unmapped read not zero");
  a_adv_hold: assert property ($changed(adv_out) |-> age_reg <= 3'h3)
    else $error("advert changed without restart");
  a_fc_hold: assert property ($changed(adv_fc_out) |-> age_reg <= 3'h3)
    else $error("pause advert changed without restart");
  a_restart_drop: assert property (age_reg == 3'h1 |=> !link_up_out)
    else $error("link kept over restart");
  a_mdix_cause: assert property ($rose(mdix_out) |-> $past(pair_swapped_in, 3))
    else $error("pair swap without cause");
  a_pol_cause: assert property ($rose(pol_inv_out) |-> $past(pol_reversed_in, 3))
    else $error("polarity flip without cause");
  c_gig: cover property (link_up_out && speed_out == SPD_1000);
  c_ten: cover property (link_up_out && speed_out == SPD_10);
  c_mdix: cover property (mdix_out && pol_inv_out);
endmodule // panc_top_properties
bind panc_top panc_top_properties #(.SETTLE(SETTLE)) i_panc_top_properties (
  .clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .pair_swapped_in, .pol_reversed_in, .adv_out, .adv_fc_out, .link_up_out,
  .speed_out, .full_dup_out, .mdix_out, .pol_inv_out);

// ===== sim/panc_partner.sv
// model: link partner port on the cable
`timescale 1ns/1ps
module panc_partner (
  // clock and setup
  input  wire logic       clk_in,
  input  wire logic       an_in,
  input  wire logic [5:0] abil_in,
  input  wire logic [1:0] spd_in,
  input  wire logic       known_in,
  // cable side
  output logic            an_out = 1'b0,
  output logic      [5:0] abil_out = 6'h00,
  output logic            valid_out = 1'b0,
  output logic      [1:0] spd_out = 2'h0,
  output logic            known_out = 1'b0,
  output logic            full_out = 1'b0,
  output logic            swap_out = 1'b1,
  output logic            rev_out = 1'b1
);
  logic t_reg = 1'b0;
  // ability lines toggle without negotiation, unknown duplex toggles
  always @(posedge clk_in) begin
    t_reg     <= ~t_reg;
    an_out    <= an_in;
    abil_out  <= an_in ? abil_in : {6{t_reg}};
    valid_out <= 1'b1;
    spd_out   <= spd_in;
    known_out <= known_in;
    full_out  <= known_in | t_reg;
  end
endmodule // panc_partner

// ===== sim/panc_top_tb.sv
// testbench: register driven link setup scenarios for panc_top
`timescale 1ns/1ps
`define CHK(n, e, v) begin n_tests++; if ((v) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, v); end end
module panc_top_tb;
  import panc_pkg::*;
  logic clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, d;
  logic [5:0] adv_out, p_abil = 6'h3f, pa;
  logic p_an = 1'b1, p_kn = 1'b0, pan, pv, pk, pf, psw, prv;
  logic [1:0] p_spd = 2'h0, ps, speed_out;
  logic adv_fc_out, link_up_out, full_dup_out, mdix_out, pol_inv_out;
  int err_count = 0, n_tests = 0;
  always #12.5 clk_in = ~clk_in;
  panc_partner i_panc_partner (.clk_in(clk_in), .an_in(p_an),
    .abil_in(p_abil), .spd_in(p_spd), .known_in(p_kn), .an_out(pan),
    .abil_out(pa), .valid_out(pv), .spd_out(ps), .known_out(pk),
    .full_out(pf), .swap_out(psw), .rev_out(prv));
  panc_top #(.SETTLE(4)) i_panc_top (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .partner_an_in(pan), .partner_adv_in(pa),
    .sense_valid_in(pv), .sense_speed_in(ps), .sense_dup_known_in(pk),
    .sense_full_in(pf), .pair_swapped_in(psw), .pol_reversed_in(prv),
    .adv_out(adv_out), .adv_fc_out(adv_fc_out), .link_up_out(link_up_out),
    .speed_out(speed_out), .full_dup_out(full_dup_out),
    .mdix_out(mdix_out), .pol_inv_out(pol_inv_out));
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1; addr_in <= a; wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic run(input logic [7:0] c, input logic [5:0] ad,
      input logic an, input logic [5:0] pb, input logic [1:0] sp,
      input logic kn, input logic [7:0] ex, input logic [7:0] mk);
    logic [7:0] v;
    @(posedge clk_in);
    p_an <= an; p_abil <= pb; p_spd <= sp; p_kn <= kn;
    repeat (4) @(posedge clk_in);
    wr(OFS_ADV, {2'h0, ad});
    wr(OFS_CTRL, c | 8'h08);
    repeat (40) @(posedge clk_in);
    rd(OFS_LINK, v);
    `CHK("link", ex, v & mk)
    `CHK("adv", c[CTRL_CUSTOM] ? ad : ABIL_ALL, adv_out)
    `CHK("fc", c[CTRL_FC], adv_fc_out)
    `CHK("mdix", c[CTRL_AN_EN], mdix_out)
    `CHK("pol", c[CTRL_AN_EN], pol_inv_out)
    $display("test %h %h done", c, pb);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(25 * 5000);
    err_count++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    `CHK("adv reset", 6'h3f, adv_out)
    rd(OFS_CTRL, d); `CHK("ctrl reset", CTRL_RST, d)
    rd(OFS_ADV, d); `CHK("adv reg reset", ADV_RST, d)
    wr(4'h9, 8'hff);
    rd(4'h9, d); `CHK("unmapped", 8'h00, d)
    run(8'h01, 6'h3f, 1, 6'h3f, 0, 0, 8'h0d, 8'h0f);
    run(8'h01, 6'h3f, 1, 6'h0c, 0, 0, 8'h0b, 8'h0f);
    run(8'h01, 6'h3f, 1, 6'h01, 0, 0, 8'h01, 8'h0f);
    run(8'h07, 6'h04, 1, 6'h3f, 0, 0, 8'h03, 8'h0f);
    run(8'h03, 6'h03, 1, 6'h3f, 0, 0, 8'h09, 8'h0f);
    run(8'h03, 6'h08, 1, 6'h07, 0, 0, 8'h00, 8'h01);
    run(8'h03, 6'h08, 1, 6'h3f, 0, 0, 8'h0b, 8'h0f);
    run(8'h01, 6'h3f, 0, 6'h3f, 1, 0, 8'h03, 8'h0f);
    run(8'h01, 6'h3f, 0, 6'h3f, 2, 1, 8'h0d, 8'h0f);
    run(8'h00, 6'h3f, 1, 6'h3f, 0, 0, 8'h01, 8'h0f);
    run(8'h01, 6'h3f, 1, 6'h3f, 0, 0, 8'h0d, 8'h0f);
    wr(OFS_ADV, 8'h01);
    wr(OFS_CTRL, 8'h07);
    repeat (10) @(posedge clk_in);
    `CHK("held adv", 6'h3f, adv_out)
    `CHK("held fc", 1'b0, adv_fc_out)
    rd(OFS_LINK, d); `CHK("held link", 8'h0d, d)
    rd(OFS_CTRL, d); `CHK("ctrl", 8'h07, d)
    rd(OFS_STATUS, d); `CHK("status", 8'h1b, d)
    $display("test hold done");
    close_out;
  end
endmodule // panc_top_tb
